//--- gyrout_map.svh
// offsets, field positions and constants of the gyro output registers
`ifndef GYROUT_MAP_SVH
`define GYROUT_MAP_SVH

`define GYROUT_ADDR_W 7
`define GYROUT_X_RATE_LOW 7'h04
`define GYROUT_X_RATE_HIGH 7'h06
`define GYROUT_Y_RATE_LOW 7'h08
`define GYROUT_Y_RATE_HIGH 7'h0a
`define GYROUT_Z_RATE_LOW 7'h0c
`define GYROUT_Z_RATE_HIGH 7'h0e
`define GYROUT_X_ANGLE_INC 7'h24
`define GYROUT_Y_ANGLE_INC 7'h26
`define GYROUT_WORD_RESET 16'h0000
`define GYROUT_UNMAPPED_BYTE 8'h00
`define GYROUT_SRC_INTERNAL 2'h0
`define GYROUT_INT_RATE_HZ 16'h0800
`define GYROUT_POS_MAX 16'h7fff
`define GYROUT_NEG_MAX 16'h8000
`define GYROUT_DIV_STEPS 5'h1f

`endif

//--- gyrout_pkg.sv
// types shared by the gyro output register block
package gyrout_pkg;

   typedef struct packed {
      logic [31:0] x;
      logic [31:0] y;
      logic [31:0] z;
   } gyrout_rate_t;

   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] data;
   } gyrout_rsp_t;

   typedef enum logic {
      GYROUT_DIV_IDLE,
      GYROUT_DIV_RUN
   } gyrout_div_state_t;

endpackage

//--- gyrout_regs.sv
// gyro rate and delta angle output registers with byte read port
//
// Functional notes
// - rate high word, 16-bit, 0.005 dps/LSB
// - low word carries filter bit growth
// - high and low form one 32-bit result
// - six read-only rate registers, latest sample
// - zero rate reads 0x0000, two's complement
// - x and y angle accumulated each processing cycle
// - angle word 16-bit two's complement, zero=0
// - angle LSB = rate LSB*(dec+1)/fsample
// - fsample 2048 Hz internal, else external rate
// - 16-bit registers, low byte at even address
`timescale 1ns/1ps
`include "gyrout_map.svh"

module gyrout_regs (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // processed samples at the sample rate
   input wire logic smp_valid,
   input wire gyrout_pkg::gyrout_rate_t smp_rate,
   // configuration from the control registers
   input wire logic [15:0] decimation_setting,
   input wire logic [1:0] clk_src,
   input wire logic [15:0] ext_rate_hz,
   // scaling status
   output logic [15:0] f_sample_hz,
   // byte read requests
   input wire logic rd_valid,
   output logic rd_ready,
   input wire logic [6:0] rd_addr,
   // byte read answers
   output logic rsp_valid,
   input wire logic rsp_ready,
   output gyrout_pkg::gyrout_rsp_t rsp
);

   gyrout_pkg::gyrout_rate_t rate;
   logic [15:0] x_angle_increment;
   logic [15:0] y_angle_increment;
   logic [31:0] acc [2];
   logic [15:0] dcnt;
   logic [31:0] dvd [2];
   logic [32:0] rem [2];
   logic neg [2];
   logic [32:0] divisor;
   logic [4:0] step;
   gyrout_pkg::gyrout_div_state_t dstate;
   gyrout_pkg::gyrout_rsp_t buf_mem [2];
   logic wptr;
   logic rptr;
   logic [1:0] count;

   function automatic logic [31:0] sext16(input logic [15:0] w);
      sext16 = {{16{w[15]}}, w};
   endfunction

   function automatic logic [31:0] abs32(input logic [31:0] v);
      abs32 = v[31] ? 32'(-v) : v;
   endfunction

   // clamp the quotient into the signed 16-bit word
   function automatic logic [15:0] sat16(input logic [31:0] mag,
                                         input logic n);
      if (n) begin
         sat16 = (mag > 32'h0000_8000) ? `GYROUT_NEG_MAX : 16'(-mag);
      end else begin
         sat16 = (mag > 32'h0000_7fff) ? `GYROUT_POS_MAX : mag[15:0];
      end
   endfunction

   // sample decimation window and running sums of the high words
   wire [31:0] next_acc_x = acc[0] + sext16(smp_rate.x[31:16]);
   wire [31:0] next_acc_y = acc[1] + sext16(smp_rate.y[31:16]);
   wire win_end = smp_valid && (dcnt == decimation_setting);
   wire div_start = win_end && (dstate == gyrout_pkg::GYROUT_DIV_IDLE);
   wire div_last = (dstate == gyrout_pkg::GYROUT_DIV_RUN) &&
                   (step == `GYROUT_DIV_STEPS);
   // window length, dec+1 samples
   wire [32:0] next_divisor =
      {17'h0, decimation_setting} + 33'h1;

   // one restoring division step per axis
   logic [32:0] shifted [2];
   logic ge [2];
   logic [31:0] next_dvd [2];
   logic [32:0] next_rem [2];
   for (genvar i = 0; i < 2; i++) begin : g_div
      assign shifted[i] = {rem[i][31:0], dvd[i][31]};
      assign ge[i] = shifted[i] >= divisor;
      assign next_dvd[i] = {dvd[i][30:0], ge[i]};
      assign next_rem[i] = ge[i] ? shifted[i] - divisor : shifted[i];
   end

   // byte read decode, low byte at the even address
   wire [6:0] word_addr = {rd_addr[6:1], 1'b0};
   logic [15:0] rd_word;
   always_comb begin
      case (word_addr)
         `GYROUT_X_RATE_LOW: rd_word = rate.x[15:0];
         `GYROUT_X_RATE_HIGH: rd_word = rate.x[31:16];
         `GYROUT_Y_RATE_LOW: rd_word = rate.y[15:0];
         `GYROUT_Y_RATE_HIGH: rd_word = rate.y[31:16];
         `GYROUT_Z_RATE_LOW: rd_word = rate.z[15:0];
         `GYROUT_Z_RATE_HIGH: rd_word = rate.z[31:16];
         `GYROUT_X_ANGLE_INC: rd_word = x_angle_increment;
         `GYROUT_Y_ANGLE_INC: rd_word = y_angle_increment;
         default: rd_word = {2{`GYROUT_UNMAPPED_BYTE}};
      endcase
   end
   wire [7:0] rd_byte = rd_addr[0] ? rd_word[15:8] :
                        rd_word[7:0];

   // two-entry answer buffer keeps byte answers across a receiver stall
   assign rd_ready = (count != 2'h2);
   assign rsp_valid = (count != 2'h0);
   assign rsp = buf_mem[rptr];
   wire push = rd_valid && rd_ready;
   wire pop = rsp_valid && rsp_ready;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wptr <= 1'b0;
         rptr <= 1'b0;
         count <= 2'h0;
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
      end else begin
         if (push) begin
            buf_mem[wptr] <= '{addr: rd_addr, data: rd_byte};
            wptr <= ~wptr;
         end
         if (pop) begin
            rptr <= ~rptr;
         end
         count <= 2'(count + {1'b0, push} - {1'b0, pop});
      end
   end

   // whole 32-bit result latched at once so both words stay coherent
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rate <= {3{`GYROUT_WORD_RESET, `GYROUT_WORD_RESET}};
      end else if (smp_valid) begin
         rate <= smp_rate;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         f_sample_hz <= `GYROUT_INT_RATE_HZ;
      end else begin
         f_sample_hz <= (clk_src == `GYROUT_SRC_INTERNAL) ?
                        `GYROUT_INT_RATE_HZ : ext_rate_hz;
      end
   end

   // sum over dec+1 samples is in rate-LSB/fsample units; dividing by
   // dec+1 gives the scaled angle word
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         acc[0] <= 32'h0;
         acc[1] <= 32'h0;
         dcnt <= 16'h0;
      end else if (win_end) begin
         acc[0] <= 32'h0;
         acc[1] <= 32'h0;
         dcnt <= 16'h0;
      end else if (smp_valid) begin
         acc[0] <= next_acc_x;
         acc[1] <= next_acc_y;
         dcnt <= 16'(dcnt + 16'h1);
      end
   end

   // a window closing mid-division is dropped; samples are far slower
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dstate <= gyrout_pkg::GYROUT_DIV_IDLE;
         step <= 5'h0;
         divisor <= 33'h0;
         for (int i = 0; i < 2; i++) begin
            dvd[i] <= 32'h0;
            rem[i] <= 33'h0;
            neg[i] <= 1'b0;
         end
      end else begin
         case (dstate)
            gyrout_pkg::GYROUT_DIV_IDLE: begin
               if (div_start) begin
                  divisor <= next_divisor;
                  dvd[0] <= abs32(next_acc_x);
                  dvd[1] <= abs32(next_acc_y);
                  neg[0] <= next_acc_x[31];
                  neg[1] <= next_acc_y[31];
                  rem[0] <= 33'h0;
                  rem[1] <= 33'h0;
                  step <= 5'h0;
                  dstate <= gyrout_pkg::GYROUT_DIV_RUN;
               end
            end
            gyrout_pkg::GYROUT_DIV_RUN: begin
               for (int i = 0; i < 2; i++) begin
                  dvd[i] <= next_dvd[i];
                  rem[i] <= next_rem[i];
               end
               step <= 5'(step + 5'h1);
               if (div_last) begin
                  dstate <= gyrout_pkg::GYROUT_DIV_IDLE;
               end
            end
            default: dstate <= gyrout_pkg::GYROUT_DIV_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         x_angle_increment <= `GYROUT_WORD_RESET;
         y_angle_increment <= `GYROUT_WORD_RESET;
      end else if (div_last) begin
         x_angle_increment <= sat16(next_dvd[0], neg[0]);
         y_angle_increment <= sat16(next_dvd[1], neg[1]);
      end
   end

endmodule

//--- gyrout_regs_properties.sv
// assertions on the gyro output register ports
`timescale 1ns/1ps
module gyrout_chk (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // samples and configuration
   input wire logic smp_valid,
   input wire gyrout_pkg::gyrout_rate_t smp_rate,
   input wire logic [1:0] clk_src,
   input wire logic [15:0] ext_rate_hz,
   input wire logic [15:0] f_sample_hz,
   // byte read port
   input wire logic rd_valid,
   input wire logic rd_ready,
   input wire logic [6:0] rd_addr,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire gyrout_pkg::gyrout_rsp_t rsp
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // reads into an empty buffer answer on the very next cycle
   wire take = rd_valid && rd_ready && !rsp_valid;
   logic [15:0] last_bytes;
   always_ff @(posedge clk) begin
      if (!reset_n)
         last_bytes <= 16'h0000;
      else if (smp_valid)
         last_bytes <= {smp_rate.z[31:24], smp_rate.x[7:0]};
   end
   chk_fs_internal: assert property (
      clk_src == 2'h0 |=> f_sample_hz == 16'h0800) else $error("bad fs");
   chk_fs_external: assert property (
      clk_src != 2'h0 |=> f_sample_hz == $past(ext_rate_hz))
      else $error("bad external fs");
   chk_answer_addr: assert property (
      take |=> rsp_valid && rsp.addr == $past(rd_addr)) else $error("addr");
   chk_rsp_hold: assert property (
      rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
      else $error("hold");
   chk_full_refuse: assert property (!rd_ready |-> rsp_valid)
      else $error("refused while empty");
   chk_unmapped_zero: assert property (
      take && rd_addr == 7'h20 |=> rsp.data == 8'h00) else $error("unmapped");
   chk_low_byte: assert property (
      take && rd_addr == 7'h04 && !smp_valid |=> rsp.data == last_bytes[7:0])
      else $error("low byte");
   chk_high_byte: assert property (
      take && rd_addr == 7'h0f && !smp_valid |=> rsp.data == last_bytes[15:8])
      else $error("high byte");
endmodule
bind gyrout_regs gyrout_chk u_chk (.clk(clk), .reset_n(reset_n),
   .smp_valid(smp_valid), .smp_rate(smp_rate), .clk_src(clk_src),
   .ext_rate_hz(ext_rate_hz), .f_sample_hz(f_sample_hz),
   .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr),
   .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));

//--- gyrout_host.sv
// host-side taker of byte answers, able to stall
`timescale 1ns/1ps
module gyrout_host (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // stall controls
   input wire logic hold,
   input wire logic slow,
   // answer handshake
   output logic rsp_ready
);
   logic [1:0] cnt;
   always_ff @(posedge clk) begin
      cnt <= reset_n ? cnt + 2'h1 : 2'h0;
   end
   // slow is ready one cycle in four, one byte a transfer
   assign rsp_ready = !hold && (!slow || cnt == 2'h3);
endmodule

//--- gyrout_regs_tb.sv
// self-checking bench for the gyro output registers
`timescale 1ns/1ps
module gyrout_regs_tb;
   logic clk, reset_n, smp_valid, rd_valid, rd_ready, hold, slow;
   logic rsp_valid, rsp_ready;
   logic [1:0] clk_src;
   logic [15:0] ext_rate_hz, f_sample_hz, v, lo, dec;
   logic [6:0] rd_addr;
   logic [7:0] d;
   gyrout_pkg::gyrout_rate_t smp_rate;
   gyrout_pkg::gyrout_rsp_t rsp;
   int err_count = 0, checked = 0, cyc = 0;
   gyrout_regs u_dut (.clk(clk), .reset_n(reset_n), .smp_valid(smp_valid),
      .smp_rate(smp_rate), .decimation_setting(dec),
      .clk_src(clk_src), .ext_rate_hz(ext_rate_hz),
      .f_sample_hz(f_sample_hz), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_addr(rd_addr), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp(rsp));
   gyrout_host u_host (.clk(clk), .reset_n(reset_n), .hold(hold),
      .slow(slow), .rsp_ready(rsp_ready));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask
   task wrap_up;
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task rd(input logic [6:0] a, output logic [7:0] q);
      int n;
      rd_valid <= 1'b1;
      rd_addr <= a;
      @(posedge clk);
      while (!rd_ready) @(posedge clk);
      rd_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(rsp_valid && rsp_ready) && n < 50);
      chk("rsp addr", {9'h0, rsp.addr}, {9'h0, a});
      q = rsp.data;
   endtask
   task rd16(input logic [6:0] a, output logic [15:0] q);
      logic [7:0] l, h;
      rd(a, l);
      rd(a + 7'h1, h);
      q = {h, l};
   endtask
   task smp(input logic [95:0] s);
      smp_rate <= s;
      smp_valid <= 1'b1;
      @(posedge clk);
      smp_valid <= 1'b0;
      repeat (40) @(posedge clk);
   endtask
   task rates(input logic [95:0] s);
      logic [95:0] w;
      logic [7:0] e;
      w = {s[31:0], s[63:32], s[95:64]};
      for (int a = 4; a < 16; a++) begin
         rd(a[6:0], d);
         e = w[8*(a-4) +: 8];
         chk("rate", {8'h0, d}, {8'h0, e});
      end
   endtask
   task t_reset;
      rates(96'h0);
      rd16(7'h24, v);
      chk("x angle", v, 16'h0000);
      rd(7'h20, d);
      chk("unmapped", {8'h0, d}, 16'h0000);
      chk("fs", f_sample_hz, 16'h0800);
   endtask
   task t_samples;
      smp({32'h0004abcd, 32'hfffd1234, 32'h0});
      rates({32'h0004abcd, 32'hfffd1234, 32'h0});
      rd16(7'h24, v);
      chk("open window", v, 16'h0000);
      smp({32'h00078001, 32'hfffc7ffe, 32'hb1e00010});
      rates({32'h00078001, 32'hfffc7ffe, 32'hb1e00010});
      rd16(7'h24, v);
      chk("x angle", v, 16'h0005);
      rd16(7'h26, v);
      chk("y angle", v, 16'hfffd);
      // host keeping 20 bits: high word plus top nibble of the low word
      rd16(7'h06, v);
      rd16(7'h04, lo);
      chk("x 20-bit", {v[11:0], lo[15:12]}, 16'h0078);
   endtask
   // single-sample window: angle equals the high word
   task t_dec;
      dec <= 16'h0000;
      smp({32'h8000ffff, 32'h00020000, 32'h0});
      rd16(7'h24, v);
      chk("x angle d0", v, 16'h8000);
      rd16(7'h26, v);
      chk("y angle d0", v, 16'h0002);
   endtask
   // reset in mid-run must clear data left by earlier samples
   task t_mid_reset;
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd16(7'h06, v);
      chk("x rate reset", v, 16'h0000);
      rd16(7'h24, v);
      chk("x angle reset", v, 16'h0000);
   endtask
   task t_full;
      int n;
      hold <= 1'b1;
      rd_valid <= 1'b1;
      rd_addr <= 7'h0a;
      repeat (4) @(posedge clk);
      chk("full refuses", {15'h0, rd_ready}, 16'h0000);
      rd_valid <= 1'b0;
      hold <= 1'b0;
      slow <= 1'b1;
      n = 0;
      repeat (16) begin
         @(posedge clk);
         if (rsp_valid && rsp_ready)
            n++;
      end
      chk("drained", n[15:0], 16'h0002);
      slow <= 1'b0;
   endtask
   task t_fs;
      clk_src <= 2'h1;
      ext_rate_hz <= 16'h07d0;
      repeat (3) @(posedge clk);
      chk("fs external", f_sample_hz, 16'h07d0);
      clk_src <= 2'h0;
      repeat (3) @(posedge clk);
      chk("fs internal", f_sample_hz, 16'h0800);
   endtask
   // ceiling well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up;
      end
   end
   initial begin
      reset_n = 1'b0;
      smp_valid = 1'b0;
      smp_rate = '0;
      clk_src = 2'h0;
      ext_rate_hz = 16'h0000;
      dec = 16'h0001;
      rd_valid = 1'b0;
      rd_addr = 7'h00;
      hold = 1'b0;
      slow = 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_samples;
      t_dec;
      t_mid_reset;
      t_full;
      t_fs;
      wrap_up;
   end
endmodule
